// ### design/hdsa_adapter.v
// How it works
// - Bit rate programmable 20 to 16383.5 bps in half-bps steps.
// - Formats: 5 bits, 6 or 7 bits plus parity, 8 bits.
// - Transmit and receive are never active together.
// - Breaks on the receive line are ignored while transmitting.
// - Break character in 5/6/7-bit format holds space three character times.
// - Peer dropping its ready line during input flags end of file.
// - Receiver stops storing once the input buffer is full.
// - Input ends on input end-of-block character or full buffer.
// - Equal new-line and end-of-block gives one record per operation.
// - Received codes are stored unchanged.
// - Ignore, wait and set modes bend the RTS/CTS conventions.
// - Modem and terminal modes use the full half-duplex control set.
// - Software selects terminal or modem role toward the peer.
// - Code E3 sends output new-line; FF sends end-of-block and ends.
`include "hdsa_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module hdsa_adapter #(
  parameter LENW = 16
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       ce,
  input  wire [7:0] addr,
  input  wire [31:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [31:0] rdata,
  output wire       irq,
  output reg        line_out,
  input  wire       line_in,
  output reg        rts_out,
  input  wire       cts_in,
  output reg        cts_out,
  input  wire       rts_in,
  output reg        ready_out,
  input  wire       ready_in
);
  localparam T_IDLE = 2'd0;
  localparam T_HS   = 2'd1;
  localparam T_SEND = 2'd2;
  localparam R_IDLE  = 2'd0;
  localparam R_START = 2'd1;
  localparam R_BITS  = 2'd2;
  localparam [28:0] MODULUS = 2 * `HDSA_CLK_HZ;
  // ************************************************************
  // Registers
  // ************************************************************
  reg  [7:0]      ctrl;
  reg  [14:0]     rate2;
  reg  [31:0]     chars;
  reg  [7:0]      brk_char;
  reg  [LENW-1:0] buf_len;
  reg  [LENW-1:0] rx_cnt;
  reg  [5:0]      stat;
  reg  [5:0]      mask;
  reg  [7:0]      rx_data;
  reg  [7:0]      tx_hold;
  reg             tx_pend;
  reg             rx_act;
  reg             ready_q;
  reg  [28:0]     acc;
  reg             tick;
  reg  [1:0]      tx_st;
  reg  [3:0]      tx_sub;
  reg  [10:0]     tx_sh;
  reg             tx_fill;
  reg  [4:0]      tx_bits;
  reg             tx_last;
  reg  [1:0]      rx_st;
  reg  [3:0]      rx_sub;
  reg  [3:0]      rx_k;
  reg  [9:0]      rx_sh;
  wire [1:0] fmt   = ctrl[1:0];
  wire       podd  = ctrl[2];
  wire       dce   = ctrl[3];
  wire [2:0] hs    = ctrl[6:4];
  wire       onl   = ctrl[7];
  wire [7:0] in_nl  = chars[7:0];
  wire [7:0] in_eob = chars[15:8];
  wire [7:0] out_nl = chars[23:16];
  wire [7:0] out_eob = chars[31:24];
  wire       std_hs = (hs == `HDSA_HS_MODEM) || (hs == `HDSA_HS_TERM);
  // Frame length in bits, start and stop included.
  wire [3:0] nb = (fmt == 2'd0) ? 4'd7 : (fmt == 2'd1) ? 4'd9 : 4'd10;
  wire [3:0] ndat = 4'd5 + {2'b00, fmt};
  wire       wr_a = ce & wr;
  wire [5:0] ev;
  wire [31:0] cnt_ext = {{(32-LENW){1'b0}}, rx_cnt};
  // ************************************************************
  // Bit-rate generator
  // ************************************************************
  // A phase accumulator in half-bps units gives exact 0.5 bps
  // resolution with no rounding drift across the range.
  wire [28:0] step = {10'h000, rate2, 4'h0};
  wire [29:0] sum  = {1'b0, acc} + {1'b0, step};
  always @(posedge clk)
  begin
    if (reset)
    begin
      acc  <= 29'h0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      if (sum >= {1'b0, MODULUS})
      begin
        acc  <= sum[28:0] - MODULUS;
        tick <= 1'b1;
      end
      else
      begin
        acc  <= sum[28:0];
        tick <= 1'b0;
      end
    end
  end
  // ************************************************************
  // Handshake lines
  // ************************************************************
  reg go;
  always @*
  begin
    case (hs)
      `HDSA_HS_IGN:  go = 1'b1;
      `HDSA_HS_WAIT: go = dce ? rts_in : cts_in;
      `HDSA_HS_SET:  go = 1'b1;
      default:       go = dce ? 1'b1 : cts_in;
    endcase
  end
  always @(posedge clk)
  begin
    if (reset)
    begin
      rts_out   <= 1'b0;
      cts_out   <= 1'b0;
      ready_out <= 1'b0;
    end
    else if (ce)
    begin
      ready_out <= onl;
      if (std_hs)
      begin
        rts_out <= ~dce & (tx_st != T_IDLE);
        cts_out <= dce & rts_in & (tx_st == T_IDLE) & (rx_st == R_IDLE);
      end
      else
      begin
        rts_out <= (hs == `HDSA_HS_SET);
        cts_out <= (hs == `HDSA_HS_SET);
      end
    end
  end
  // ************************************************************
  // Transmitter
  // ************************************************************
  function [10:0] frame_of;
    input [1:0] f;
    input       odd;
    input [7:0] c;
    begin
      case (f)
        2'd0:    frame_of = {5'h1F, c[4:0], 1'b0};
        2'd1:    frame_of = {3'h7, odd ^ (^c[5:0]), c[5:0], 1'b0};
        2'd2:    frame_of = {2'h3, odd ^ (^c[6:0]), c[6:0], 1'b0};
        default: frame_of = {2'h3, c, 1'b0};
      endcase
    end
  endfunction
  wire is_brk = (tx_hold == brk_char) && (fmt != `HDSA_FMT_8);
  reg [7:0] tx_ch;
  always @*
  begin
    case (tx_hold)
      `HDSA_CODE_NL:  tx_ch = out_nl;
      `HDSA_CODE_END: tx_ch = out_eob;
      default:        tx_ch = tx_hold;
    endcase
  end
  wire tx_end = tick & (tx_sub == `HDSA_SUB_LAST) & (tx_bits == 5'd1);
  always @(posedge clk)
  begin
    if (reset)
    begin
      tx_st    <= T_IDLE;
      tx_sub   <= 4'h0;
      tx_sh    <= 11'h7FF;
      tx_fill  <= 1'b1;
      tx_bits  <= 5'd0;
      tx_last  <= 1'b0;
      tx_pend  <= 1'b0;
      tx_hold  <= 8'h00;
      line_out <= 1'b1;
    end
    else if (ce)
    begin
      if (wr_a && addr == `HDSA_A_TXD && !tx_pend)
      begin
        tx_hold <= wdata[7:0];
        tx_pend <= 1'b1;
      end
      case (tx_st)
        T_IDLE:
        begin
          line_out <= 1'b1;
          if (tx_pend && onl && rx_st == R_IDLE)
            tx_st <= T_HS;
        end
        T_HS:
        begin
          if (rx_st != R_IDLE)
            tx_st <= T_IDLE;
          else if (go)
          begin
            tx_pend <= 1'b0;
            tx_sub  <= 4'h0;
            tx_last <= (tx_hold == `HDSA_CODE_END);
            if (is_brk)
            begin
              tx_sh   <= 11'h000;
              tx_fill <= 1'b0;
              tx_bits <= {1'b0, nb} + {1'b0, nb} + {1'b0, nb};
            end
            else
            begin
              tx_sh   <= frame_of(fmt, podd, tx_ch);
              tx_fill <= 1'b1;
              tx_bits <= {1'b0, nb};
            end
            tx_st <= T_SEND;
          end
        end
        T_SEND:
        begin
          line_out <= tx_sh[0];
          if (tick)
          begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == `HDSA_SUB_LAST)
            begin
              tx_sh   <= {tx_fill, tx_sh[10:1]};
              tx_bits <= tx_bits - 5'd1;
              if (tx_bits == 5'd1)
                tx_st <= T_IDLE;
            end
          end
        end
        default: tx_st <= T_IDLE;
      endcase
    end
  end
  // ************************************************************
  // Receiver
  // ************************************************************
  wire [3:0] nk   = nb - 4'd1;
  // The last bit is judged in the cycle that shifts it in, so decode from
  // the shift value that includes the bit now on the line.
  wire [9:0] rx_nsh = {line_in, rx_sh[9:1]};
  wire [9:0] word = rx_nsh >> (4'd10 - nk);
  wire [7:0] dmask = ~(8'hFF << ndat);
  wire [7:0] rx_d  = word[7:0] & dmask;
  wire       rx_stop = word[nk - 4'd1];
  wire rx_done = tick & (rx_st == R_BITS) & (rx_sub == `HDSA_SUB_LAST)
                 & (rx_k == nk - 4'd1);
  wire rx_brk   = rx_done & (rx_d == 8'h00) & ~rx_stop & (tx_st == T_IDLE);
  wire rx_store = rx_done & rx_stop & rx_act;
  wire at_eob   = rx_store & (rx_d == in_eob);
  wire at_full  = rx_store & ~at_eob & (rx_cnt + 1'b1 == buf_len);
  wire eof      = rx_act & ready_q & ~ready_in;
  always @(posedge clk)
  begin
    if (reset)
    begin
      rx_st   <= R_IDLE;
      rx_sub  <= 4'h0;
      rx_k    <= 4'h0;
      rx_sh   <= 10'h000;
      rx_data <= 8'h00;
      rx_cnt  <= {LENW{1'b0}};
      rx_act  <= 1'b0;
      ready_q <= 1'b0;
    end
    else if (ce)
    begin
      ready_q <= ready_in;
      case (rx_st)
        R_IDLE:
          if (tick && !line_in && tx_st == T_IDLE)
          begin
            rx_st  <= R_START;
            rx_sub <= 4'h0;
          end
        R_START:
          if (tick)
          begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `HDSA_SUB_MID)
            begin
              rx_st  <= line_in ? R_IDLE : R_BITS;
              rx_sub <= 4'h0;
              rx_k   <= 4'h0;
            end
          end
        R_BITS:
          if (tick)
          begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `HDSA_SUB_LAST)
            begin
              rx_sh <= {line_in, rx_sh[9:1]};
              rx_k  <= rx_k + 4'h1;
              if (rx_k == nk - 4'd1)
                rx_st <= R_IDLE;
            end
          end
        default: rx_st <= R_IDLE;
      endcase
      if (rx_store)
      begin
        rx_data <= rx_d;
        rx_cnt  <= rx_cnt + 1'b1;
      end
      if (wr_a && addr == `HDSA_A_CMD && wdata[0])
      begin
        rx_act <= 1'b1;
        rx_cnt <= {LENW{1'b0}};
      end
      else if (at_eob || at_full || eof || (wr_a && addr == `HDSA_A_CMD
               && wdata[1]))
        rx_act <= 1'b0;
    end
  end
  // ************************************************************
  // Software registers and interrupt
  // ************************************************************
  assign ev = {rx_brk, tx_end & tx_last, eof, at_full, at_eob, rx_store};
  assign irq = |(stat & mask);
  always @(posedge clk)
  begin
    if (reset)
    begin
      ctrl     <= `HDSA_CTRL_RST;
      rate2    <= `HDSA_RATE_RST;
      chars    <= `HDSA_CHARS_RST;
      brk_char <= `HDSA_BRKC_RST;
      buf_len  <= `HDSA_LEN_RST;
      stat     <= 6'h00;
      mask     <= 6'h00;
      rdata    <= 32'h0;
    end
    else if (ce)
    begin
      // A new event wins over a write-one-to-clear in the same cycle.
      if (wr_a && addr == `HDSA_A_STAT)
        stat <= (stat & ~wdata[5:0]) | ev;
      else
        stat <= stat | ev;
      if (wr_a)
      begin
        case (addr)
          `HDSA_A_CTRL:  ctrl <= wdata[7:0];
          `HDSA_A_RATE:  rate2 <= wdata[14:0];
          `HDSA_A_CHARS: chars <= wdata;
          `HDSA_A_BRKC:  brk_char <= wdata[7:0];
          `HDSA_A_LEN:   buf_len <= wdata[LENW-1:0];
          `HDSA_A_MASK:  mask <= wdata[5:0];
          default:       ;
        endcase
      end
      if (rd)
      begin
        case (addr)
          `HDSA_A_CTRL:  rdata <= {24'h0, ctrl};
          `HDSA_A_RATE:  rdata <= {17'h0, rate2};
          `HDSA_A_CHARS: rdata <= chars;
          `HDSA_A_BRKC:  rdata <= {24'h0, brk_char};
          `HDSA_A_RXD:   rdata <= {24'h0, rx_data};
          `HDSA_A_LEN:   rdata <= {{(32-LENW){1'b0}}, buf_len};
          `HDSA_A_STAT:  rdata <= {26'h0, stat};
          `HDSA_A_MASK:  rdata <= {26'h0, mask};
          `HDSA_A_STATE: rdata <= {cnt_ext[15:0], 8'h0,
                                   rx_act, tx_pend, rx_st, tx_st, 2'b00};
          default:       rdata <= 32'h0;
        endcase
      end
      else
        rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ### design/hdsa_defines.vh
`ifndef HDSA_DEFINES_VH
`define HDSA_DEFINES_VH
// ************************************************************
// Register map
// ************************************************************
`define HDSA_A_CTRL  8'h00
`define HDSA_A_RATE  8'h04
`define HDSA_A_CHARS 8'h08
`define HDSA_A_BRKC  8'h0C
`define HDSA_A_TXD   8'h10
`define HDSA_A_RXD   8'h14
`define HDSA_A_LEN   8'h18
`define HDSA_A_CMD   8'h1C
`define HDSA_A_STAT  8'h20
`define HDSA_A_MASK  8'h24
`define HDSA_A_STATE 8'h28
// ************************************************************
// Fields and reset values
// ************************************************************
`define HDSA_CTRL_RST  8'h80
`define HDSA_RATE_RST  15'h0258
`define HDSA_CHARS_RST 32'hFF15FF15
`define HDSA_BRKC_RST  8'h00
`define HDSA_LEN_RST   16'h0050
`define HDSA_FMT_8     2'h3
`define HDSA_HS_MODEM  3'h0
`define HDSA_HS_TERM   3'h1
`define HDSA_HS_IGN    3'h2
`define HDSA_HS_WAIT   3'h3
`define HDSA_HS_SET    3'h4
`define HDSA_CODE_NL   8'hE3
`define HDSA_CODE_END  8'hFF
`define HDSA_EV_RXCHR  0
`define HDSA_EV_RXEOB  1
`define HDSA_EV_RXFULL 2
`define HDSA_EV_EOF    3
`define HDSA_EV_TXEOB  4
`define HDSA_EV_BRK    5
// ************************************************************
// Timing
// ************************************************************
`define HDSA_CLK_HZ    125000000
`define HDSA_OVERSAMP  16
`define HDSA_SUB_LAST  4'hF
`define HDSA_SUB_MID   4'h7
`endif

// ### verification/hdsa_monitor.sv
`include "hdsa_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module hdsa_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq,
  input wire logic        line_out,
  input wire logic        line_in,
  input wire logic        rts_out,
  input wire logic        cts_in,
  input wire logic        cts_out,
  input wire logic        rts_in,
  input wire logic        ready_out,
  input wire logic        ready_in
);
  logic [2:0] mode;
  logic       role;
  logic [1:0] since;
  // ****
  // Shadow of the handshake setup.
  // ****
  // Outputs are judged only three edges after a setup write, so the
  // registered handshake lines have had time to follow.
  always @(posedge clk)
  begin
    if (reset)
    begin
      mode  <= 3'h0;
      role  <= 1'b0;
      since <= 2'h0;
    end
    else if (ce && wr && addr == `HDSA_A_CTRL)
    begin
      mode  <= wdata[6:4];
      role  <= wdata[3];
      since <= 2'h0;
    end
    else if (ce && since != 2'h3)
    begin
      since <= since + 2'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_rdata_idle: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("read data left standing");
  a_unmapped_zero: assert property (ce && rd && (addr > `HDSA_A_STATE
    || addr[1:0] != 2'h0) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ready_follows: assert property (
    ce && wr && addr == `HDSA_A_CTRL |=> ##1 ready_out == $past(wdata[7], 2))
    else $error("ready line not following setup");
  a_ready_reads: assert property (
    ce && rd && addr == `HDSA_A_CTRL |=> rdata[7] == ready_out)
    else $error("ready line differs from setup");
  a_release_idle: assert property (
    $fell(reset) |-> line_out && !rts_out && !cts_out && rdata == 32'h0)
    else $error("lines not idle after reset");
  a_set_asserts: assert property (
    since == 2'h3 && mode == `HDSA_HS_SET |-> rts_out && cts_out)
    else $error("set mode lines low");
  a_ignore_quiet: assert property (
    since == 2'h3 && mode == `HDSA_HS_IGN |-> !rts_out && !cts_out)
    else $error("ignore mode lines high");
  a_role_lines: assert property (
    since == 2'h3 && mode < `HDSA_HS_IGN |-> (role ? !rts_out : !cts_out))
    else $error("role drives wrong line");
  c_rx_read: cover property (rd && addr == `HDSA_A_RXD);
  c_irq_up: cover property ($rose(irq));
  c_tx_start: cover property ($fell(line_out));
endmodule
bind hdsa_adapter hdsa_monitor i_mon (
  .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .line_out(line_out),
  .line_in(line_in), .rts_out(rts_out), .cts_in(cts_in),
  .cts_out(cts_out), .rts_in(rts_in), .ready_out(ready_out),
  .ready_in(ready_in)
);
`default_nettype wire

// ### verification/hdsa_peer.sv
`timescale 1ns/1ps
`default_nettype none
module hdsa_peer #(
  parameter int BIT = 7629
) (
  input  wire logic clk,
  input  wire logic line_out,
  input  wire logic hold_space,
  output logic      line_in
);
  logic       drv = 1'b1;
  logic [4:0] got = 5'h0;
  int         n = 0;
  int         k;
  int         j;
  // A long space overrides framing, as a misbehaving peer would.
  assign line_in = drv & ~hold_space;
  always
  begin
    @(negedge line_out);
    repeat (BIT / 2) @(posedge clk);
    for (k = 0; k < 5; k++)
    begin
      repeat (BIT) @(posedge clk);
      got[k] = line_out;
    end
    repeat (BIT) @(posedge clk);
    n++;
  end
  task automatic send(input logic [4:0] d);
  begin
    @(posedge clk);
    drv <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (j = 0; j < 5; j++)
    begin
      drv <= d[j];
      repeat (BIT) @(posedge clk);
    end
    drv <= 1'b1;
    repeat (BIT) @(posedge clk);
  end
  endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`include "hdsa_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rts_in = 1'b0;
  logic        cts_in = 1'b0;
  logic        ready_in = 1'b1;
  logic        brk = 1'b0;
  logic [31:0] v;
  logic [39:0] t;
  logic [7:0]  c;
  wire  [31:0] rdata;
  wire         irq, line_out, line_in, rts_out, cts_out, ready_out;
  integer      fails = 0;
  integer      total_checks = 0;
  integer      seed = 47441;
  integer      i;
  integer      m;
  always #4 clk = ~clk;
  hdsa_adapter i_dut (
    .clk(clk), .reset(reset), .ce(1'b1), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .line_out(line_out),
    .line_in(line_in), .rts_out(rts_out), .cts_in(cts_in),
    .cts_out(cts_out), .rts_in(rts_in), .ready_out(ready_out),
    .ready_in(ready_in)
  );
  hdsa_peer i_peer (
    .clk(clk), .line_out(line_out), .hold_space(brk), .line_in(line_in)
  );
  function automatic [31:0] ctrl_word(input [2:0] md, input rl, input on);
    ctrl_word = {24'h0, on, md, rl, 3'h0};
  endfunction
  function automatic [2:0] hs_exp(input [2:0] md, input rl, on, rq);
    hs_exp = {on, md == `HDSA_HS_SET, md == `HDSA_HS_SET};
    if (md < `HDSA_HS_IGN && rl)
      hs_exp[0] = rq;
  endfunction
  function automatic [39:0] rst_tab(input integer n);
    case (n)
      0: rst_tab = {`HDSA_A_CTRL, 24'h0, `HDSA_CTRL_RST};
      1: rst_tab = {`HDSA_A_RATE, 17'h0, `HDSA_RATE_RST};
      2: rst_tab = {`HDSA_A_CHARS, `HDSA_CHARS_RST};
      3: rst_tab = {`HDSA_A_LEN, 16'h0, `HDSA_LEN_RST};
      4: rst_tab = {`HDSA_A_BRKC, 24'h0, `HDSA_BRKC_RST};
      default: rst_tab = {8'h2C, 32'h0};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  end
  endtask
  task automatic rreg(input logic [7:0] a);
  begin
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  end
  endtask
  task automatic end_sim;
  begin
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #1000000;
    fails = fails + 1;
    end_sim;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 6; i = i + 1)
    begin
      t = rst_tab(i);
      rreg(t[39:32]);
      chk(v, t[31:0]);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      m = $random(seed);
      wreg(`HDSA_A_BRKC, 32'(m));
      rreg(`HDSA_A_BRKC);
      chk(v, 32'(m) & 32'hFF);
    end
    for (i = 0; i < 10; i = i + 1)
    begin
      m = $random(seed);
      wreg(`HDSA_A_CTRL, ctrl_word(i[3:1], i[0], m[2]));
      rts_in <= m[0];
      cts_in <= m[1];
      repeat (4) @(posedge clk);
      #1;
      chk({ready_out, rts_out, cts_out}, hs_exp(i[3:1], i[0], m[2], m[0]));
    end
    m = $random(seed);
    c = {3'h0, m[7:3]};
    wreg(`HDSA_A_RATE, 32'h00007FFF);
    wreg(`HDSA_A_BRKC, 32'h000000E0);
    wreg(`HDSA_A_CTRL, ctrl_word(`HDSA_HS_IGN, 1'b0, 1'b1));
    wreg(`HDSA_A_TXD, {24'h0, c});
    for (i = 0; i < 2000 && line_out; i = i + 1)
      @(posedge clk);
    brk <= 1'b1;
    for (i = 0; i < 100000 && i_peer.n == 0; i = i + 1)
      @(posedge clk);
    brk <= 1'b0;
    chk(32'(i_peer.got), {24'h0, c});
    chk(32'(line_out), 32'h1);
    v = 32'h40;
    for (i = 0; i < 9000 && v[6:2] != 5'h0; i = i + 1)
      rreg(`HDSA_A_STATE);
    rreg(`HDSA_A_STAT);
    chk(v, 32'h0);
    c = {3'h0, m[12:8]};
    if (c == 8'h15)
      c = 8'h0A;
    wreg(`HDSA_A_MASK, 32'h1);
    wreg(`HDSA_A_CMD, 32'h1);
    i_peer.send(c[4:0]);
    for (i = 0; i < 20 && irq !== 1'b1; i = i + 1)
      @(posedge clk);
    rreg(`HDSA_A_RXD);
    chk(v, {24'h0, c});
    chk(32'(i_peer.n), 32'h1);
    wreg(`HDSA_A_STAT, 32'h3F);
    wreg(`HDSA_A_MASK, 32'h8);
    ready_in <= 1'b0;
    #1;
    chk(32'(irq), 32'h0);
    for (i = 0; i < 20 && irq !== 1'b1; i = i + 1)
      @(posedge clk);
    rreg(`HDSA_A_STAT);
    chk(v, 32'h8);
    end_sim;
  end
endmodule
`default_nettype wire
